// ---- logic/ash_alarm_ctl.sv ----
// Purpose: Alarm stop and alarm-release handshake of a stepping motor driver
// Assumes: Inputs synchronous to pclk; fault_valid marks a detected fault
// Notes:   Registers over APB; history of recent alarms kept in ash_hist_mem
//
// Behaviour
// - On an alarm, alarm-ok, motion-active and pulse-ready drop together.
// - Step output stops at the alarm, no deceleration.
// - After release, incoming pulses drive the motor at once.
// - Alarm-clear releases the alarm; alarm-ok, ready, pulse-ready come back.
// - Same outputs and sequence whether the motor stays excited or not; only excite differs.
// - Keep the last ten alarms, newest first, with code and sub code.
`timescale 1ns/1ns
module ash_alarm_ctl (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ash_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output      logic [31:0]                 prdata,
  output      logic                        pready,
  output      logic                        pslverr,
  // Fault detection
  input  wire logic                        fault_valid,
  input  wire ash_pkg::ash_alarm_t         fault_info,
  // Host I/O
  input  wire logic                        pulse_in,
  input  wire logic                        alarm_clear_input,
  output      logic                        alarm_ok_output,
  output      logic                        motion_active_output,
  output      logic                        ready_output,
  output      logic                        pulse_accept_ready_output,
  // Motor drive
  output      logic                        step_output,
  output      logic                        excite_output,
  // Interrupt
  output      logic                        irq
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [ash_pkg::ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic mapped(input logic [ash_pkg::ADDR_W-1:0] a);
    mapped = hit(a, ash_pkg::OFF_CTRL) | hit(a, ash_pkg::OFF_STAT) | hit(a, ash_pkg::OFF_IRQ) |
             hit(a, ash_pkg::OFF_MASK) | hit(a, ash_pkg::OFF_HSEL) | hit(a, ash_pkg::OFF_HDATA);
  endfunction

  localparam logic [ash_pkg::HOLD_W-1:0]  HOLD_LOAD = ash_pkg::HOLD_W'(ash_pkg::MOVE_HOLD_CYC);
  localparam logic [ash_pkg::HIST_AW-1:0] HIST_LAST = ash_pkg::HIST_AW'(ash_pkg::HIST_DEPTH - 1);
  localparam logic [ash_pkg::HIST_AW-1:0] HIST_FULL = ash_pkg::HIST_AW'(ash_pkg::HIST_DEPTH);
  localparam logic [4:0]                  HIST_D5   = 5'(ash_pkg::HIST_DEPTH);

  ash_pkg::ash_state_t s_ff;
  ash_pkg::ash_state_t nxt_s;
  ash_pkg::ash_alarm_t hist_rdata;
  logic                hist_we;
  logic                clr_rise;
  logic                raise_ev;
  logic                release_ev;
  logic [4:0]          rd_idx;
  logic [ash_pkg::HIST_AW-1:0] hist_raddr;

  ////////////////////////////////////////////////////////////////////////////
  // Newest entry sits just behind the write pointer
  always_comb begin
    rd_idx = 5'(s_ff.wptr) + HIST_D5 - 5'd1 - 5'(s_ff.hsel);
    if (rd_idx >= HIST_D5) begin
      rd_idx = rd_idx - HIST_D5;
    end
    hist_raddr = rd_idx[ash_pkg::HIST_AW-1:0];
  end

  ash_hist_mem u_hist (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (hist_we),
    .waddr   (s_ff.wptr),
    .wdata   (fault_info),
    .raddr   (hist_raddr),
    .rdata   (hist_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s      = s_ff;
    clr_rise   = alarm_clear_input & ~s_ff.clr_prev;
    raise_ev   = 1'b0;
    release_ev = 1'b0;
    hist_we    = 1'b0;
    nxt_s.clr_prev = alarm_clear_input;

    // Fault outranks a clear edge in the same cycle
    unique case (s_ff.mode)
      ash_pkg::ASH_RUN: begin
        if (fault_valid) begin
          nxt_s.mode = ash_pkg::ASH_ALARM;
          nxt_s.cur  = fault_info;
          raise_ev   = 1'b1;
        end
      end
      ash_pkg::ASH_ALARM: begin
        if (!fault_valid && clr_rise) begin
          nxt_s.mode = ash_pkg::ASH_RUN;
          release_ev = 1'b1;
        end
      end
    endcase

    // Entry written at the entry edge, so the pointer bump keeps newest just behind it
    hist_we = raise_ev;
    if (raise_ev) begin
      nxt_s.wptr   = (s_ff.wptr == HIST_LAST) ? '0 : s_ff.wptr + 1'b1;
      nxt_s.hcount = (s_ff.hcount == HIST_FULL) ? HIST_FULL : s_ff.hcount + 1'b1;
    end

    // Steps gated by the next mode: stop and resume take effect at once
    nxt_s.step = pulse_in & s_ff.ctrl[ash_pkg::CTRL_EN_BIT] &
                 (nxt_s.mode == ash_pkg::ASH_RUN);
    if (nxt_s.mode == ash_pkg::ASH_ALARM) begin
      nxt_s.hold = '0;
    end else if (nxt_s.step) begin
      nxt_s.hold = HOLD_LOAD;
    end else if (s_ff.hold != '0) begin
      nxt_s.hold = s_ff.hold - 1'b1;
    end

    // APB: read data captured in setup so pready can be constant high
    if (psel && !penable && !pwrite) begin
      nxt_s.prdata = '0;
      if (hit(paddr, ash_pkg::OFF_CTRL)) begin
        nxt_s.prdata[1:0] = s_ff.ctrl;
      end
      if (hit(paddr, ash_pkg::OFF_STAT)) begin
        nxt_s.prdata[ash_pkg::STAT_ALARM_BIT] = (s_ff.mode == ash_pkg::ASH_ALARM);
        nxt_s.prdata[ash_pkg::STAT_OK_BIT]    = alarm_ok_output;
        nxt_s.prdata[ash_pkg::STAT_MOVE_BIT]  = motion_active_output;
        nxt_s.prdata[ash_pkg::STAT_PRDY_BIT]  = pulse_accept_ready_output;
        nxt_s.prdata[ash_pkg::STAT_READY_BIT] = ready_output;
        nxt_s.prdata[ash_pkg::STAT_EXC_BIT]   = excite_output;
        nxt_s.prdata[ash_pkg::STAT_CODE_LSB +: ash_pkg::CODE_W] = s_ff.cur.code;
        nxt_s.prdata[ash_pkg::STAT_SUB_LSB +: ash_pkg::CODE_W]  = s_ff.cur.sub;
      end
      if (hit(paddr, ash_pkg::OFF_IRQ)) begin
        nxt_s.prdata[1:0] = s_ff.irq_stat;
      end
      if (hit(paddr, ash_pkg::OFF_MASK)) begin
        nxt_s.prdata[1:0] = s_ff.irq_mask;
      end
      if (hit(paddr, ash_pkg::OFF_HSEL)) begin
        nxt_s.prdata[ash_pkg::HIST_AW-1:0] = s_ff.hsel;
        nxt_s.prdata[ash_pkg::HSEL_CNT_LSB +: ash_pkg::HIST_AW] = s_ff.hcount;
      end
      if (hit(paddr, ash_pkg::OFF_HDATA) && s_ff.hsel < s_ff.hcount) begin
        nxt_s.prdata[15:0] = hist_rdata;
      end
    end

    // Read clears only what was reported, so a new event survives
    if (psel && penable && !pwrite && hit(paddr, ash_pkg::OFF_IRQ)) begin
      nxt_s.irq_stat = s_ff.irq_stat & ~s_ff.prdata[1:0];
    end
    nxt_s.irq_stat[ash_pkg::IRQ_RAISE_BIT] = nxt_s.irq_stat[ash_pkg::IRQ_RAISE_BIT] | raise_ev;
    nxt_s.irq_stat[ash_pkg::IRQ_CLEAR_BIT] = nxt_s.irq_stat[ash_pkg::IRQ_CLEAR_BIT] | release_ev;

    if (psel && penable && pwrite) begin
      if (hit(paddr, ash_pkg::OFF_CTRL)) begin
        nxt_s.ctrl = pwdata[1:0];
      end
      if (hit(paddr, ash_pkg::OFF_MASK)) begin
        nxt_s.irq_mask = pwdata[1:0];
      end
      if (hit(paddr, ash_pkg::OFF_HSEL)) begin
        nxt_s.hsel = pwdata[ash_pkg::HIST_AW-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff          <= '0;
      s_ff.mode     <= ash_pkg::ASH_RUN;
      s_ff.ctrl     <= ash_pkg::CTRL_RST;
      s_ff.irq_mask <= ash_pkg::MASK_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs identical whatever the excitation choice; only excite differs
  always_comb begin
    prdata                    = s_ff.prdata;
    pready                    = 1'b1;
    pslverr                   = psel & penable & ~mapped(paddr);
    alarm_ok_output           = (s_ff.mode == ash_pkg::ASH_RUN);
    ready_output              = alarm_ok_output & s_ff.ctrl[ash_pkg::CTRL_EN_BIT];
    pulse_accept_ready_output = ready_output;
    motion_active_output      = (s_ff.hold != '0);
    step_output               = s_ff.step;
    excite_output             = s_ff.ctrl[ash_pkg::CTRL_EN_BIT] &
                                (alarm_ok_output | s_ff.ctrl[ash_pkg::CTRL_KEEP_BIT]);
    irq                       = |(s_ff.irq_stat & s_ff.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence fault_in_run;
    s_ff.mode == ash_pkg::ASH_RUN && fault_valid;
  endsequence
  sequence clear_edge_in_alarm;
    s_ff.mode == ash_pkg::ASH_ALARM && !fault_valid && alarm_clear_input && !s_ff.clr_prev;
  endsequence

  outputs_drop_a: assert property (fault_in_run |=>
    !alarm_ok_output && !motion_active_output && !pulse_accept_ready_output)
    else $error("alarm outputs did not drop together");
  step_stop_a: assert property (fault_valid |=> !step_output [*2])
    else $error("steps continued after fault");
  pulse_resume_a: assert property (clear_edge_in_alarm ##0 (pulse_in && s_ff.ctrl[0]) |=>
    step_output && motion_active_output)
    else $error("pulse not accepted right after release");
  release_out_a: assert property (clear_edge_in_alarm ##0 s_ff.ctrl[0] |=>
    alarm_ok_output && ready_output && pulse_accept_ready_output)
    else $error("release did not restore outputs");
  same_sequence_a: assert property (s_ff.mode == ash_pkg::ASH_ALARM |->
    !alarm_ok_output && !ready_output && !pulse_accept_ready_output && !step_output)
    else $error("alarm outputs depend on excitation");
  hist_count_a: assert property (fault_in_run |=>
    s_ff.hcount == (($past(s_ff.hcount) == HIST_FULL) ? HIST_FULL : $past(s_ff.hcount) + 1'b1))
    else $error("history count wrong after alarm");
  held_clear_a: assert property (s_ff.mode == ash_pkg::ASH_ALARM && alarm_clear_input && s_ff.clr_prev |=>
    s_ff.mode == ash_pkg::ASH_ALARM)
    else $error("held clear released an alarm");
  irq_raise_a: assert property (fault_in_run ##0 s_ff.irq_mask[0] |=> irq [*2])
    else $error("alarm interrupt missing");

endmodule

// ---- logic/ash_hist_mem.sv ----
// Purpose: Small history memory with registered read data
// Assumes: One write port, one read port, same clock
// Notes:   Array is not reset; readers gate by the fill count
`timescale 1ns/1ns
module ash_hist_mem #(
  parameter int unsigned DEPTH = ash_pkg::HIST_DEPTH,
  parameter int unsigned AW    = ash_pkg::HIST_AW
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Write port
  input  wire logic               we,
  input  wire logic [AW-1:0]      waddr,
  input  wire ash_pkg::ash_alarm_t wdata,
  // Read port
  input  wire logic [AW-1:0]      raddr,
  output      ash_pkg::ash_alarm_t rdata
);

  ash_pkg::ash_alarm_t mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ---- logic/ash_pkg.sv ----
// Purpose: Shared constants and types for the alarm stop and release block
// Assumes: APB data 32 bits, one aligned word per register
// Notes:   All offsets are byte addresses
package ash_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_STAT  = 8'h04;
  localparam logic [7:0] OFF_IRQ   = 8'h08;
  localparam logic [7:0] OFF_MASK  = 8'h0C;
  localparam logic [7:0] OFF_HSEL  = 8'h10;
  localparam logic [7:0] OFF_HDATA = 8'h14;

  // Control register
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_KEEP_BIT = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h1;

  // Status register fields
  localparam int unsigned STAT_ALARM_BIT = 0;
  localparam int unsigned STAT_OK_BIT    = 1;
  localparam int unsigned STAT_MOVE_BIT  = 2;
  localparam int unsigned STAT_PRDY_BIT  = 3;
  localparam int unsigned STAT_READY_BIT = 4;
  localparam int unsigned STAT_EXC_BIT   = 5;
  localparam int unsigned STAT_CODE_LSB  = 8;
  localparam int unsigned STAT_SUB_LSB   = 16;

  // Interrupt status and mask
  localparam int unsigned IRQ_RAISE_BIT = 0;
  localparam int unsigned IRQ_CLEAR_BIT = 1;
  localparam logic [1:0]  MASK_RST      = 2'h0;

  // Alarm history
  localparam int unsigned HIST_DEPTH    = 10;
  localparam int unsigned HIST_AW       = 4;
  localparam int unsigned HSEL_CNT_LSB  = 8;
  localparam int unsigned CODE_W        = 8;

  // Motion-active hold after the last step
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MOVE_HOLD_NS  = 2000;
  localparam int unsigned MOVE_HOLD_CYC = (MOVE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_W        = 6;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic {
    ASH_RUN,
    ASH_ALARM
  } ash_mode_t;

  typedef struct packed {
    logic [CODE_W-1:0] sub;
    logic [CODE_W-1:0] code;
  } ash_alarm_t;

  typedef struct packed {
    ash_mode_t          mode;
    ash_alarm_t         cur;
    logic               clr_prev;
    logic               step;
    logic [HOLD_W-1:0]  hold;
    logic [1:0]         ctrl;
    logic [1:0]         irq_stat;
    logic [1:0]         irq_mask;
    logic [HIST_AW-1:0] hsel;
    logic [HIST_AW-1:0] wptr;
    logic [HIST_AW-1:0] hcount;
    logic [31:0]        prdata;
  } ash_state_t;

endpackage

// ---- sim/ash_alarm_ctl_tb.sv ----
// Purpose: Self-checking bench for the alarm stop and release block
// Assumes: APB master waits for pready, never counts on latency
// Notes:   Checks are made at the falling edge, APB checks in acc at the rising edge; drives follow rising edges
`timescale 1ns/1ns
module ash_alarm_ctl_tb;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata;
  logic               fault_valid, pulse_in, alarm_clear_input, alarm_ok_output, motion_active_output;
  ash_pkg::ash_alarm_t fault_info;
  logic               ready_output, pulse_accept_ready_output, step_output, excite_output, irq;
  logic               run, rel_req, keep_pulses, hold_clr, rel_done, s;
  int                 error_cnt, checked;

  ash_alarm_ctl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_valid(fault_valid), .fault_info(fault_info), .pulse_in(pulse_in),
    .alarm_clear_input(alarm_clear_input), .alarm_ok_output(alarm_ok_output),
    .motion_active_output(motion_active_output), .ready_output(ready_output),
    .pulse_accept_ready_output(pulse_accept_ready_output), .step_output(step_output),
    .excite_output(excite_output), .irq(irq));
  ash_host_model host (.pclk(pclk), .presetn(presetn), .run(run), .rel_req(rel_req),
    .keep_pulses(keep_pulses), .hold_clr(hold_clr), .alarm_ok_output(alarm_ok_output),
    .pulse_in(pulse_in), .alarm_clear_input(alarm_clear_input), .rel_done(rel_done));

  always #20 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Starts just after a rising edge, returns just after one
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
                     input logic eexp);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        chk(32'h0, 32'h1);
        final_report();
      end
      @(posedge pclk);
    end
    if (!w) chk(prdata, exp);
    chk({31'h0, pslverr}, {31'h0, eexp});
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Fault seen for one cycle, ends at the next falling edge
  task automatic fault(input logic [15:0] info);
    fault_valid <= 1'b1;
    fault_info  <= ash_pkg::ash_alarm_t'(info);
    @(posedge pclk);
    fault_valid <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic release_alarm;
    int n;
    n = 0;
    rel_req <= 1'b1;
    @(posedge pclk);
    while (rel_done !== 1'b1 && !(hold_clr && alarm_ok_output === 1'b1)) begin
      n++;
      if (n > 50) begin
        chk(32'h0, 32'h1);
        final_report();
      end
      @(posedge pclk);
    end
    rel_req <= 1'b0;
    @(negedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; fault_valid = 1'b0; fault_info = '0; run = 1'b0; rel_req = 1'b0;
    keep_pulses = 1'b0; hold_clr = 1'b0; error_cnt = 0; checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    acc(1'b0, ash_pkg::OFF_CTRL, 32'h0, 32'h1, 1'b0);
    acc(1'b0, ash_pkg::OFF_MASK, 32'h0, 32'h0, 1'b0);
    acc(1'b0, ash_pkg::OFF_STAT, 32'h0, 32'h3A, 1'b0);
    acc(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
    acc(1'b1, 8'h20, 32'h5, 32'h0, 1'b1);
    $display("Test reset and map done");
    // Alarm while stepping, motor de-excited
    acc(1'b1, ash_pkg::OFF_MASK, 32'h3, 32'h0, 1'b0);
    run <= 1'b1;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, motion_active_output}, 32'h1);
    @(posedge pclk);
    fault(16'h0143);
    chk({alarm_ok_output, motion_active_output, pulse_accept_ready_output, ready_output, step_output}, 32'h0);
    chk({excite_output, irq}, 32'h1);
    @(posedge pclk);
    acc(1'b0, ash_pkg::OFF_STAT, 32'h0, 32'h00014301, 1'b0);
    acc(1'b0, ash_pkg::OFF_IRQ, 32'h0, 32'h1, 1'b0);
    @(negedge pclk);
    chk({irq, step_output}, 32'h0);
    @(posedge pclk);
    release_alarm();
    chk({alarm_ok_output, ready_output, pulse_accept_ready_output, alarm_clear_input}, 32'hE);
    @(posedge pclk);
    acc(1'b0, ash_pkg::OFF_IRQ, 32'h0, 32'h2, 1'b0);
    $display("Test alarm and release done");
    // Excited mode, pulses kept running through the release
    acc(1'b1, ash_pkg::OFF_CTRL, 32'h3, 32'h0, 1'b0);
    acc(1'b1, ash_pkg::OFF_MASK, 32'h1, 32'h0, 1'b0);
    keep_pulses <= 1'b1;
    fault(16'h000A);
    chk({alarm_ok_output, motion_active_output, pulse_accept_ready_output, ready_output, step_output}, 32'h0);
    chk({31'h0, excite_output}, 32'h1);
    @(posedge pclk);
    acc(1'b0, ash_pkg::OFF_STAT, 32'h0, 32'h00000A21, 1'b0);
    release_alarm();
    s = step_output;
    @(negedge pclk);
    chk({30'h0, s | step_output, irq}, 32'h3);
    @(posedge pclk);
    acc(1'b0, ash_pkg::OFF_IRQ, 32'h0, 32'h3, 1'b0);
    keep_pulses <= 1'b0;
    run         <= 1'b0;
    acc(1'b1, ash_pkg::OFF_CTRL, 32'h1, 32'h0, 1'b0);
    $display("Test excited mode done");
    // Clear held high across a new alarm
    fault(16'h001E);
    @(posedge pclk);
    hold_clr <= 1'b1;
    release_alarm();
    @(posedge pclk);
    fault(16'h0221);
    repeat (4) @(negedge pclk);
    chk({alarm_ok_output, alarm_clear_input}, 32'h1);
    @(posedge pclk);
    hold_clr <= 1'b0;
    repeat (4) @(posedge pclk);
    release_alarm();
    chk({31'h0, alarm_ok_output}, 32'h1);
    @(posedge pclk);
    $display("Test held clear done");
    // History fills to its depth, newest first
    for (int i = 0; i < 8; i++) begin
      fault({8'h00, 8'(8'h50 + i)});
      @(posedge pclk);
      release_alarm();
      @(posedge pclk);
    end
    acc(1'b1, ash_pkg::OFF_HSEL, 32'h0, 32'h0, 1'b0);
    acc(1'b0, ash_pkg::OFF_HDATA, 32'h0, 32'h0057, 1'b0);
    acc(1'b1, ash_pkg::OFF_HSEL, 32'h9, 32'h0, 1'b0);
    acc(1'b0, ash_pkg::OFF_HSEL, 32'h0, 32'h0A09, 1'b0);
    acc(1'b0, ash_pkg::OFF_HDATA, 32'h0, 32'h001E, 1'b0);
    $display("Test history done");
    final_report();
  end
endmodule

// ---- sim/ash_host_model.sv ----
// Purpose: Host controller model for the alarm release handshake
// Assumes: Bench commands change just after a rising edge
// Notes:   keep_pulses and hold_clr are deliberate misbehaviour, bench-commanded
`timescale 1ns/1ns
module ash_host_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Bench commands
  input  wire logic run,
  input  wire logic rel_req,
  input  wire logic keep_pulses,
  input  wire logic hold_clr,
  // Device side
  input  wire logic alarm_ok_output,
  output      logic pulse_in,
  output      logic alarm_clear_input,
  output      logic rel_done
);
  logic [1:0] st_ff;
  logic [1:0] wait_ff;
  logic       seen_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff             <= 2'h0;
      wait_ff           <= 2'h0;
      seen_ff           <= 1'b0;
      pulse_in          <= 1'b0;
      alarm_clear_input <= 1'b0;
      rel_done          <= 1'b0;
    end else begin
      pulse_in <= (run && (st_ff == 2'h0 || keep_pulses)) ? !pulse_in : 1'b0;
      case (st_ff)
        2'h0: if (rel_req) begin
          st_ff   <= 2'h1;
          wait_ff <= 2'h0;
          seen_ff <= 1'b0;
        end
        2'h1: begin
          // Pulses stay quiet a few cycles before the clear edge unless keep_pulses is set
          wait_ff <= wait_ff + 2'h1;
          if (wait_ff == 2'h3) begin
            alarm_clear_input <= 1'b1;
            st_ff             <= 2'h2;
          end
        end
        2'h2: begin
          seen_ff <= seen_ff | alarm_ok_output;
          if ((seen_ff || alarm_ok_output) && !hold_clr) begin
            alarm_clear_input <= 1'b0;
            st_ff             <= 2'h3;
          end
        end
        default: begin
          rel_done <= rel_req;
          if (!rel_req) st_ff <= 2'h0;
        end
      endcase
    end
  end
endmodule
